// >>> src/dq_vref_pkg.sv
// Constants for the data-bus reference-level mode register
package dq_vref_pkg;
    localparam logic [5:0] DQ_REFERENCE_LEVEL_ADDR = 6'h0E;
    localparam logic [5:0] SET_POINT_CONTROL_ADDR = 6'h0D;
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_W = 6;
    localparam int RANGE_BIT = 6;
    localparam int RESERVED_BIT = 7;
    localparam int WRITE_SELECT_BIT = 6;
    localparam int OPERATE_SELECT_BIT = 7;
    localparam logic [5:0] LEVEL_RESET = 6'h0D;
    localparam logic RANGE_RESET = 1'b1;
    localparam logic [5:0] LEVEL_MAX = 6'h32;
    localparam logic [1:0] SET_POINT_CTRL_RESET = 2'h0;
    localparam int READ_LATENCY = 1;
    typedef enum logic [1:0] {CMD_IDLE, CMD_WRITE, CMD_READ} cmd_t;
endpackage

// >>> src/set_point_copy.sv
// One frequency-set-point copy of the reference-level register
`timescale 1ns/1ns
module set_point_copy (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    // Stored value
    output logic [dq_vref_pkg::LEVEL_W-1:0] level_out,
    output logic range_out
);
    import dq_vref_pkg::*;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_out <= LEVEL_RESET;
            range_out <= RANGE_RESET;
        end else if (wr_en_in) begin
            // Level and range always taken together
            level_out <= wr_data_in[LEVEL_LSB +: LEVEL_W];
            range_out <= wr_data_in[RANGE_BIT];
        end
    end
endmodule

// >>> src/dq_reference_level_register.sv
// Reference-level mode register with two set-point copies
//
// Function
// - Hold a 6-bit level and a range bit for each of two set points.
// - A mode read of this address returns the stored bits on data lines 7:0.
// - Reserved bit and unused data lines read as zero.
// - Level writes go to the copy named by the write-select bit.
// - Range bit write switches the addressed copy between range 0 and 1.
// - Values stay until overwritten or reset.
// - Writes and reads touch only the copy named by write-select.
// - Operation uses only the copy named by operate-select.
// - Range bit of each copy resets to 1.
`timescale 1ns/1ns
module dq_reference_level_register #(
    parameter int DQ_WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Mode register command
    input wire logic mrw_in,
    input wire logic mrr_in,
    input wire logic [5:0] mode_addr_in,
    input wire logic [7:0] mode_data_in,
    // Read data
    output logic [DQ_WIDTH-1:0] dq_out,
    output logic dq_valid_out,
    // Operating reference setting
    output logic [dq_vref_pkg::LEVEL_W-1:0] level_active_out,
    output logic range_active_out,
    output logic level_reserved_out
);
    import dq_vref_pkg::*;

    // Read word needs all eight register bits on the data lines
    if (DQ_WIDTH < 8) begin : g_width_check
        $error("DQ_WIDTH must be at least 8");
    end

    // Other addresses are dropped silently, with no error flag
    function automatic logic addr_hit(input logic strobe, input logic [5:0] addr,
        input logic [5:0] target);
        return strobe && addr == target;
    endfunction

    logic write_select_reg;
    logic operate_select_reg;
    logic [5:0] level_copy [2];
    logic range_copy [2];
    logic [1:0] copy_wr;

    // Set-point control bits live in the neighbouring mode register
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            write_select_reg <= SET_POINT_CTRL_RESET[0];
            operate_select_reg <= SET_POINT_CTRL_RESET[1];
        end else if (addr_hit(mrw_in, mode_addr_in, SET_POINT_CONTROL_ADDR)) begin
            write_select_reg <= mode_data_in[WRITE_SELECT_BIT];
            operate_select_reg <= mode_data_in[OPERATE_SELECT_BIT];
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_copy
            assign copy_wr[i] = addr_hit(mrw_in, mode_addr_in, DQ_REFERENCE_LEVEL_ADDR)
                && write_select_reg == 1'(i);
            set_point_copy u_copy (
                .sys_clk_in(sys_clk_in),
                .rstn_in(rstn_in),
                .wr_en_in(copy_wr[i]),
                .wr_data_in(mode_data_in),
                .level_out(level_copy[i]),
                .range_out(range_copy[i])
            );
        end
    endgenerate

    // Read returns the write-selected copy, reserved bit forced low
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dq_out <= '0;
            dq_valid_out <= 1'b0;
        end else begin
            dq_valid_out <= addr_hit(mrr_in, mode_addr_in, DQ_REFERENCE_LEVEL_ADDR);
            if (addr_hit(mrr_in, mode_addr_in, DQ_REFERENCE_LEVEL_ADDR)) begin
                dq_out <= DQ_WIDTH'({1'b0, range_copy[write_select_reg],
                    level_copy[write_select_reg]});
            end else begin
                dq_out <= '0;
            end
        end
    end

    // Inactive copy can be rewritten without disturbing these
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_active_out <= LEVEL_RESET;
            range_active_out <= RANGE_RESET;
            level_reserved_out <= 1'b0;
        end else begin
            level_active_out <= level_copy[operate_select_reg];
            range_active_out <= range_copy[operate_select_reg];
            level_reserved_out <= level_copy[operate_select_reg] > LEVEL_MAX;
        end
    end

    property p_write_lands;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (mrw_in && mode_addr_in == DQ_REFERENCE_LEVEL_ADDR)
        |=> level_copy[$past(write_select_reg)] == $past(mode_data_in[5:0]);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("level write lost");

    property p_range_lands;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (mrw_in && mode_addr_in == DQ_REFERENCE_LEVEL_ADDR)
        |=> range_copy[$past(write_select_reg)] == $past(mode_data_in[6]);
    endproperty
    a_range_lands: assert property (p_range_lands) else $error("range write lost");

    property p_other_kept;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (mrw_in && mode_addr_in == DQ_REFERENCE_LEVEL_ADDR)
        |=> level_copy[!$past(write_select_reg)] == $past(level_copy[!write_select_reg]);
    endproperty
    a_other_kept: assert property (p_other_kept) else $error("wrong copy written");

    property p_hold;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !mrw_in |=> $stable(level_copy[0]) && $stable(level_copy[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("value changed without write");

    property p_read_data;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (mrr_in && mode_addr_in == DQ_REFERENCE_LEVEL_ADDR)
        |=> dq_valid_out && dq_out[6:0] == {$past(range_copy[write_select_reg]),
            $past(level_copy[write_select_reg])};
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    property p_read_zero;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        dq_out[7] == 1'b0 && (DQ_WIDTH == 8 || dq_out >> 8 == '0);
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("reserved lines not zero");

    property p_active;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ##1 level_active_out == $past(level_copy[operate_select_reg])
        && range_active_out == $past(range_copy[operate_select_reg]);
    endproperty
    a_active: assert property (p_active) else $error("active copy wrong");

    property p_reset_value;
        @(posedge sys_clk_in)
        !rstn_in |=> !rstn_in || (range_copy[0] && range_copy[1]
            && level_copy[0] == LEVEL_RESET && level_copy[1] == LEVEL_RESET);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

    property p_reset_active;
        @(posedge sys_clk_in)
        !rstn_in |=> !rstn_in || (range_active_out && level_active_out == LEVEL_RESET);
    endproperty
    a_reset_active: assert property (p_reset_active) else $error("active reset wrong");

    // Range bit of the unaddressed copy must not move either
    property p_range_kept;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        addr_hit(mrw_in, mode_addr_in, DQ_REFERENCE_LEVEL_ADDR)
        |=> range_copy[!$past(write_select_reg)] == $past(range_copy[!write_select_reg]);
    endproperty
    a_range_kept: assert property (p_range_kept) else $error("wrong range written");

    property p_range_hold;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !mrw_in |=> $stable(range_copy[0]) && $stable(range_copy[1]);
    endproperty
    a_range_hold: assert property (p_range_hold) else $error("range changed without write");

    property p_select_write;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        addr_hit(mrw_in, mode_addr_in, SET_POINT_CONTROL_ADDR)
        |=> write_select_reg == $past(mode_data_in[WRITE_SELECT_BIT])
        && operate_select_reg == $past(mode_data_in[OPERATE_SELECT_BIT]);
    endproperty
    a_select_write: assert property (p_select_write) else $error("select write lost");

    property p_valid_source;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        dq_valid_out |-> $past(addr_hit(mrr_in, mode_addr_in, DQ_REFERENCE_LEVEL_ADDR));
    endproperty
    a_valid_source: assert property (p_valid_source) else $error("read without command");

    property p_idle_zero;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !dq_valid_out |-> dq_out == '0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data lines not idle");

    // Only one copy can change per edge, so level_active_out must hold
    property p_inactive;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $changed(level_copy[!operate_select_reg]) && $stable(operate_select_reg)
        |=> $stable(level_active_out);
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive copy used");

    property p_reserved_flag;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        level_reserved_out == (level_active_out > LEVEL_MAX);
    endproperty
    a_reserved_flag: assert property (p_reserved_flag) else $error("reserved flag wrong");

    c_write_sp1: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        copy_wr[1]);
    c_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        dq_valid_out && dq_out[6]);
    c_switch: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(operate_select_reg));
    c_read_sp1: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        dq_valid_out && $past(write_select_reg));
    c_range0_active: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $fell(range_active_out));
endmodule

// >>> tb/mode_cmd_ctrl.sv
// Controller model issuing mode register commands
`timescale 1ns/1ns
module mode_cmd_ctrl (
    // Clock
    input wire logic sys_clk_in,
    // Command
    output logic mrw_out,
    output logic mrr_out,
    output logic [5:0] addr_out,
    output logic [7:0] data_out
);
    initial begin
        mrw_out = 1'b0;
        mrr_out = 1'b0;
        addr_out = 6'h00;
        data_out = 8'h00;
    end
    // One-cycle strobe; operand inverted afterwards so stale data never matches
    task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        mrw_out <= wr;
        mrr_out <= ~wr;
        addr_out <= a;
        data_out <= d;
        @(posedge sys_clk_in);
        mrw_out <= 1'b0;
        mrr_out <= 1'b0;
        addr_out <= ~a;
        data_out <= ~d;
    endtask
    // Range always sent with the level; codes above the top are never sent
    task automatic set_level(input logic rng, input logic [5:0] lvl);
        cmd(1'b1, 6'h0E, {1'b0, rng, (lvl > 6'h32) ? 6'h32 : lvl});
    endtask
endmodule

// >>> tb/test_dq_reference_level_register.sv
// Self-checking bench for the reference-level mode register
`timescale 1ns/1ns
module test_dq_reference_level_register;
    import dq_vref_pkg::*;
    logic sys_clk_in;
    logic rstn_in;
    logic mrw;
    logic mrr;
    logic [5:0] addr;
    logic [7:0] data;
    logic [15:0] dq;
    logic dq_valid;
    logic [5:0] level;
    logic range_act;
    logic reserved;
    int miscompares = 0;
    int cmp_count = 0;
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    mode_cmd_ctrl i_ctrl (.sys_clk_in(sys_clk_in), .mrw_out(mrw), .mrr_out(mrr),
        .addr_out(addr), .data_out(data));
    dq_reference_level_register #(.DQ_WIDTH(16)) i_dut (.sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in), .mrw_in(mrw), .mrr_in(mrr), .mode_addr_in(addr),
        .mode_data_in(data), .dq_out(dq), .dq_valid_out(dq_valid),
        .level_active_out(level), .range_active_out(range_act),
        .level_reserved_out(reserved));
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [5:0] a, input logic [15:0] exp, input logic vld);
        i_ctrl.cmd(1'b0, a, 8'h00);
        #1;
        cmp_count++;
        if (dq !== exp || dq_valid !== vld) begin
            miscompares++;
            $display("[ERR] %0t rd got %h/%h exp %h/%h", $time, dq_valid, dq, vld, exp);
        end
    endtask
    // Operating copy settles two edges after a write or select change
    task automatic chk_act(input logic [7:0] exp);
        repeat (2) @(posedge sys_clk_in);
        #1;
        cmp_count++;
        if ({reserved, range_act, level} !== exp) begin
            miscompares++;
            $display("[ERR] %0t act got %h exp %h", $time, {reserved, range_act, level}, exp);
        end
    endtask
    initial begin
        rstn_in = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        chk_act(8'h4D);
        chk_rd(6'h0E, 16'h004D, 1'b1);
        $display("test reset values done");
        i_ctrl.set_level(1'b0, 6'h32);
        chk_rd(6'h0E, 16'h0032, 1'b1);
        chk_act(8'h32);
        chk_rd(6'h0F, 16'h0000, 1'b0);
        $display("test write set point 0 done");
        i_ctrl.cmd(1'b1, 6'h0D, 8'h40);
        chk_rd(6'h0E, 16'h004D, 1'b1);
        i_ctrl.set_level(1'b1, 6'h05);
        chk_rd(6'h0E, 16'h0045, 1'b1);
        chk_act(8'h32);
        $display("test write set point 1 done");
        i_ctrl.cmd(1'b1, 6'h0D, 8'h80);
        chk_act(8'h45);
        chk_rd(6'h0E, 16'h0032, 1'b1);
        $display("test operate select done");
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        chk_rd(6'h0E, 16'h004D, 1'b1);
        chk_act(8'h4D);
        $display("test second reset done");
        end_sim();
    end
    // Hang guard
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
endmodule
